// [tb/srd_link_partner.sv]
`timescale 1ns/100ps
module srd_link_partner
    import srd_pkg::*;
(
    // link clock and rate
    input wire logic serialBitClk,
    input wire logic halfRate,
    // transmit side
    input wire logic [WORD_BITS-1:0] nextWord,
    output logic txWordClock,
    output logic [WORD_BITS-1:0] txParallelWord,
    // receive side
    input wire logic recoveredWordClock,
    input wire logic [WORD_BITS-1:0] rxParallelWord,
    input wire logic commaSeenFlag,
    output logic [WORD_BITS-1:0] gotWord,
    output logic gotFlag
);
    logic [5:0] ph;
    logic [5:0] half;
    initial
    begin
        ph = 6'h00;
        txWordClock = 1'b0;
        txParallelWord = WORD_RST;
        gotWord = WORD_RST;
        gotFlag = 1'b0;
    end
    assign half = halfRate ? 6'h14 : 6'h0A;
    // word clock at the selected rate; data changes mid-word, away from the rise
    always @(posedge serialBitClk)
    begin
        ph <= (ph >= half + half - 6'h01) ? 6'h00 : ph + 6'h01;
        txWordClock <= (ph < half);
        if (ph == half)
            txParallelWord <= nextWord;
    end
    // capture on the rising recovered clock
    always @(posedge recoveredWordClock)
    begin
        gotWord <= rxParallelWord;
        gotFlag <= commaSeenFlag;
    end
endmodule

// [tb/srd_serdes_checker.sv]
`timescale 1ns/100ps
module srd_serdes_checker
    import srd_pkg::*;
(
    // clocks and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic serialBitClk,
    // control pins
    input wire logic loopbackSelect,
    input wire logic txSpeedSel,
    input wire logic rxSpeedSel,
    input wire logic splitRateMode,
    // outputs
    input wire logic serialOutP,
    input wire logic serialOutN,
    input wire logic [WORD_BITS-1:0] rxParallelWord,
    input wire logic commaSeenFlag,
    input wire logic recoveredWordClock,
    input wire logic recoveredWordClockInv,
    input wire logic txFullSpeed,
    input wire logic rxFullSpeed
);
    logic [5:0] idle_r;
    logic [5:0] idle_nxt;
    logic rwcPrev_r;
    assign idle_nxt = (recoveredWordClock != rwcPrev_r) ? 6'h00 : idle_r + 6'h01;
    always_ff @(posedge serialBitClk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idle_r <= 6'h00;
            rwcPrev_r <= 1'b0;
        end
        else
        begin
            idle_r <= idle_nxt;
            rwcPrev_r <= recoveredWordClock;
        end
    end
    sequence s_loop_held;
        loopbackSelect [*6];
    endsequence
    sequence s_flag_word;
        commaSeenFlag [*8];
    endsequence
    property p_spd_tx;
        @(posedge core_clk) disable iff (!rst_n)
        $changed(txSpeedSel) |=> txFullSpeed == $past(txSpeedSel);
    endproperty
    property p_spd_rx;
        @(posedge core_clk) disable iff (!rst_n)
        $changed({splitRateMode, txSpeedSel, rxSpeedSel}) |=>
            rxFullSpeed == ($past(splitRateMode) ? $past(rxSpeedSel) : $past(txSpeedSel));
    endproperty
    property p_loop;
        @(posedge serialBitClk) disable iff (!rst_n)
        s_loop_held |-> serialOutP && !serialOutN;
    endproperty
    property p_pair;
        @(posedge serialBitClk) disable iff (!rst_n) serialOutN == !serialOutP;
    endproperty
    property p_inv;
        @(posedge serialBitClk) disable iff (!rst_n)
        recoveredWordClockInv == !recoveredWordClock;
    endproperty
    property p_run;
        @(posedge serialBitClk) disable iff (!rst_n) idle_r < 6'h30;
    endproperty
    property p_stable;
        @(posedge serialBitClk) disable iff (!rst_n)
        $rose(recoveredWordClock) |-> $stable(rxParallelWord) && $stable(commaSeenFlag);
    endproperty
    property p_flag_hold;
        @(posedge serialBitClk) disable iff (!rst_n) $rose(commaSeenFlag) |-> s_flag_word;
    endproperty
    property p_flag_word;
        @(posedge serialBitClk) disable iff (!rst_n)
        $changed(commaSeenFlag) |-> $changed(rxParallelWord);
    endproperty
    a_spd_tx: assert property (p_spd_tx) else $error("tx speed status wrong");
    a_spd_rx: assert property (p_spd_rx) else $error("rx speed status wrong");
    a_loop: assert property (p_loop) else $error("loopback output wrong");
    a_pair: assert property (p_pair) else $error("serial pair not complementary");
    a_inv: assert property (p_inv) else $error("recovered clock pair wrong");
    a_run: assert property (p_run) else $error("recovered clock stopped");
    a_stable: assert property (p_stable) else $error("data moved at clock rise");
    a_flag_hold: assert property (p_flag_hold) else $error("comma flag too short");
    a_flag_word: assert property (p_flag_word) else $error("flag not with word");
endmodule
bind srd_serdes_top srd_serdes_checker i_srd_serdes_checker (.core_clk, .rst_n, .serialBitClk,
    .loopbackSelect, .txSpeedSel, .rxSpeedSel, .splitRateMode, .serialOutP, .serialOutN,
    .rxParallelWord, .commaSeenFlag, .recoveredWordClock, .recoveredWordClockInv,
    .txFullSpeed, .rxFullSpeed);

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
    import srd_pkg::*;
    localparam logic [19:0] K = 20'hAA97C;
    localparam logic [19:0] S = 20'hAAF95;
    localparam logic [19:0] A = 20'hAAAAA;
    localparam logic [19:0] B = 20'h33333;
    localparam logic [19:0] C = 20'hCCCCC;
    logic core_clk, rst_n, serialBitClk, txWordClock, loopbackSelect, alignEnable;
    logic txSpeedSel, rxSpeedSel, splitRateMode, serialOutP, serialOutN, gotFlag;
    logic commaSeenFlag, recoveredWordClock, recoveredWordClockInv, txFullSpeed, rxFullSpeed;
    logic realignPulse;
    logic [19:0] txParallelWord, rxParallelWord, nextWord, gotWord;
    logic [19:0] pat [4];
    int n_mismatch = 0;
    int samples_checked = 0;
    int idx = 0;
    int nRealign = 0;
    int nBase = 0;
    srd_serdes_top i_srd_serdes_top (.core_clk, .rst_n, .serialBitClk, .loopbackSelect,
        .alignEnable, .txSpeedSel, .rxSpeedSel, .splitRateMode, .txWordClock,
        .txParallelWord, .serialOutP, .serialOutN, .serialInP(serialOutP),
        .serialInN(serialOutN), .rxParallelWord, .commaSeenFlag, .recoveredWordClock,
        .recoveredWordClockInv, .txFullSpeed, .rxFullSpeed, .realignPulse);
    srd_link_partner i_srd_link_partner (.serialBitClk, .halfRate(!txSpeedSel), .nextWord,
        .txWordClock, .txParallelWord, .recoveredWordClock, .rxParallelWord,
        .commaSeenFlag, .gotWord, .gotFlag);
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        serialBitClk = 1'b0;
        #3.7;
        forever #62.5 serialBitClk = ~serialBitClk;
    end
    always @(posedge txWordClock)
    begin
        #1;
        nextWord = pat[idx % 4];
        idx++;
    end
    // count word-boundary shifts reported in the core domain
    always @(posedge core_clk)
    begin
        if (realignPulse === 1'b1)
            nRealign++;
    end
    task automatic cmpw(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmpb(input logic got, input logic exp);
        cmpw({19'h00000, got}, {19'h00000, exp});
    endtask
    task automatic ctl(input logic lp, input logic al, input logic tx, input logic rx,
        input logic sp);
        @(posedge core_clk);
        #1;
        loopbackSelect = lp;
        alignEnable = al;
        txSpeedSel = tx;
        rxSpeedSel = rx;
        splitRateMode = sp;
    endtask
    task automatic getw(input logic [19:0] ew, input logic ef, input bit cf);
        @(posedge recoveredWordClock);
        #1;
        cmpw(gotWord, ew);
        if (cf)
            cmpb(gotFlag, ef);
    endtask
    task automatic seek();
        repeat (8) @(posedge recoveredWordClock);
        #1;
        for (int i = 0; i < 24 && gotWord !== K; i++)
        begin
            @(posedge recoveredWordClock);
            #1;
        end
        cmpw(gotWord, K);
        cmpb(gotFlag, 1'b1);
    endtask
    task automatic sync_check();
        pat = '{S, K, A, B};
        repeat (12) @(posedge txWordClock);
        pat = '{K, A, B, C};
        seek();
        repeat (2)
        begin
            getw(A, 1'b0, 1'b1);
            getw(B, 1'b0, 1'b1);
            getw(C, 1'b0, 1'b1);
            getw(K, 1'b1, 1'b1);
        end
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        rst_n = 1'b0;
        {loopbackSelect, alignEnable, splitRateMode} = 3'h0;
        {txSpeedSel, rxSpeedSel} = 2'h3;
        pat = '{A, B, C, A};
        nextWord = A;
        repeat (6) @(posedge serialBitClk);
        #1;
        cmpb(serialOutP, 1'b1);
        cmpb(recoveredWordClockInv, 1'b1);
        @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        ctl(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
        sync_check();
        cmpb(nRealign != 0, 1'b1);
        ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        pat = '{K, A, S, B};
        nBase = nRealign;
        seek();
        getw(A, 1'b0, 1'b1);
        getw(S, 1'b0, 1'b0);
        getw(B, 1'b0, 1'b1);
        cmpb(nRealign == nBase, 1'b1);
        ctl(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        sync_check();
        ctl(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        repeat (6) @(posedge serialBitClk);
        #1;
        cmpb(serialOutP, 1'b1);
        cmpb(serialOutN, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            ctl(1'b0, 1'b1, i[1], i[0], i[2]);
            @(posedge core_clk);
            #1;
            cmpb(txFullSpeed, i[1]);
            cmpb(rxFullSpeed, i[2] ? i[0] : i[1]);
        end
        results();
    end
    // watchdog
    initial
    begin
        #900000;
        n_mismatch++;
        results();
    end
endmodule

// [verilog/srd_comma_align.sv]
`timescale 1ns/100ps
module srd_comma_align
    import srd_pkg::*;
(
    // clock and reset of the link domain
    input wire logic clk,
    input wire logic rstN,
    // receive stream and assembled words
    srd_rx_if.align rx
);
    logic [WORD_BITS-1:0] shift_r, shift_nxt;
    logic [WORD_BITS-1:0] word_r, word_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;
    logic comma_r, comma_nxt;
    logic pend_r, pend_nxt;
    logic tgl_r, tgl_nxt;
    logic hit;
    logic aligned;

    always_comb
    begin
        shift_nxt = shift_r;
        word_nxt = word_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        comma_nxt = comma_r;
        pend_nxt = pend_r;
        tgl_nxt = tgl_r;
        hit = 1'b0;
        aligned = (cnt_r == CNT_CHAR_END) || (cnt_r == CNT_LAST);
        if (rx.bitStb)
        begin
            shift_nxt = {rx.serBit, shift_r[WORD_BITS-1:1]};
            // each arriving bit closes a new 10-bit window, so every offset is tried
            hit = (shift_nxt[COMMA_LSB +: COMMA_BITS] == COMMA_PAT);
            pend_nxt = pend_r | hit;
            if (hit && !aligned && rx.alignEn)
            begin
                // the comma becomes character 0; partial word is dropped
                cnt_nxt = CNT_REALIGN;
                tgl_nxt = ~tgl_r;
            end
            else if (cnt_r == CNT_LAST)
            begin
                cnt_nxt = CNT_FIRST;
                word_nxt = shift_nxt;
                done_nxt = 1'b1;
                comma_nxt = pend_nxt;
                pend_nxt = 1'b0;
            end
            else
            begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            shift_r <= WORD_RST;
            word_r <= WORD_RST;
            cnt_r <= CNT_FIRST;
            done_r <= 1'b0;
            comma_r <= 1'b0;
            pend_r <= 1'b0;
            tgl_r <= 1'b0;
        end
        else
        begin
            shift_r <= shift_nxt;
            word_r <= word_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            comma_r <= comma_nxt;
            pend_r <= pend_nxt;
            tgl_r <= tgl_nxt;
        end
    end

    assign rx.word = word_r;
    assign rx.wordDone = done_r;
    assign rx.comma = comma_r;
    assign rx.realignTgl = tgl_r;
    assign rx.bitCnt = cnt_r;
endmodule

// [verilog/srd_pkg.sv]
package srd_pkg;
    // word and character geometry
    localparam int WORD_BITS = 20;
    localparam int CHAR_BITS = 10;
    localparam int COMMA_BITS = 7;
    // comma in received order, first bit in the lsb: 0,0,1,1,1,1,1
    localparam logic [6:0] COMMA_PAT = 7'h7C;
    // lsb position of the newest character inside the assembly register
    localparam int COMMA_LSB = 10;
    // bit counter landmarks
    localparam logic [4:0] CNT_FIRST = 5'h00;
    localparam logic [4:0] CNT_CHAR_END = 5'h09;
    localparam logic [4:0] CNT_REALIGN = 5'h0A;
    localparam logic [4:0] CNT_LAST = 5'h13;
    localparam logic [4:0] RWC_RISE_CNT = 5'h09;
    // reset values
    localparam logic [19:0] WORD_RST = 20'h00000;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [1:0] SYNC_RST = 2'h0;
    // rate figures: bit clock is the base clock times this factor
    localparam int BIT_MULT = 20;
    localparam int BASE_CLK_MHZ = 125;
    localparam int HALF_RATE_DIV = 2;
    // control vector fields as carried into the link domain
    localparam int CTL_LOOP = 3;
    localparam int CTL_ALIGN = 2;
    localparam int CTL_TXFULL = 1;
    localparam int CTL_RXFULL = 0;
    typedef enum logic {SRD_HALF, SRD_FULL} srd_rate_t;
endpackage

// [verilog/srd_rx_if.sv]
`timescale 1ns/100ps
interface srd_rx_if;
    import srd_pkg::*;
    logic bitStb;
    logic serBit;
    logic alignEn;
    logic [WORD_BITS-1:0] word;
    logic wordDone;
    logic comma;
    logic realignTgl;
    logic [4:0] bitCnt;
    modport top (
        output bitStb,
        output serBit,
        output alignEn,
        input word,
        input wordDone,
        input comma,
        input realignTgl,
        input bitCnt
    );
    modport align (
        input bitStb,
        input serBit,
        input alignEn,
        output word,
        output wordDone,
        output comma,
        output realignTgl,
        output bitCnt
    );
endinterface

// [verilog/srd_serdes_top.sv]
`timescale 1ns/100ps
// Summary of operation
// - Capture the 20-bit transmit word on each rising transmit word clock.
// - Shift each word out twenty bits per word period, bit 0 first.
// - Loopback high forces serial output positive high, negative low; else data.
// - Receive serial input only while loopback is low.
// - Serial bit clock is twenty times the base clock.
// - Deserialize into two characters; recovered clock rises with data stable.
// - Recovered word clock keeps running without input data, tied to base clock; it stops while loopback is high.
// - With align enabled, search continuously for the comma 0011111.
// - Comma misaligned if not in bits 0 to 6 of a character.
// - Misaligned comma with align enabled moves word boundary to put comma first.
// - Realignment may drop up to nine bits, less than one character, before the comma.
// - Align disabled keeps the current word boundary regardless of data.
// - Comma flag high for exactly the word carrying the comma.
// - Split mode off: transmit speed select sets both directions.
// - Split mode on: each direction has its own speed select.
// - Full speed 2.5 Gb/s; half speed 1.25 Gb/s, word rate halved.
// - Recovered clocks and word rate follow the selected speeds.
module srd_serdes_top
    import srd_pkg::*;
(
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial bit clock from the synthesizer
    input wire logic serialBitClk,
    // control pins
    input wire logic loopbackSelect,
    input wire logic alignEnable,
    input wire logic txSpeedSel,
    input wire logic rxSpeedSel,
    input wire logic splitRateMode,
    // transmit parallel side
    input wire logic txWordClock,
    input wire logic [WORD_BITS-1:0] txParallelWord,
    // serial pairs
    output logic serialOutP,
    output logic serialOutN,
    input wire logic serialInP,
    input wire logic serialInN,
    // receive parallel side
    output logic [WORD_BITS-1:0] rxParallelWord,
    output logic commaSeenFlag,
    output logic recoveredWordClock,
    output logic recoveredWordClockInv,
    // core status
    output logic txFullSpeed,
    output logic rxFullSpeed,
    output logic realignPulse
);
    localparam int PIN_W = WORD_BITS + 3;

    if (WORD_BITS != 2 * CHAR_BITS)
    begin : gGeomCheck
        $error("word must hold exactly two characters");
    end

    // reset release, one copy per domain
    logic [1:0] coreRstSync_r;
    logic [1:0] linkRstSync_r;
    logic coreRstN;
    logic linkRstN;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            coreRstSync_r <= SYNC_RST;
        end
        else
        begin
            coreRstSync_r <= {coreRstSync_r[0], 1'b1};
        end
    end

    always_ff @(posedge serialBitClk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            linkRstSync_r <= SYNC_RST;
        end
        else
        begin
            linkRstSync_r <= {linkRstSync_r[0], 1'b1};
        end
    end

    assign coreRstN = coreRstSync_r[1];
    assign linkRstN = linkRstSync_r[1];

    // receive carrier, declared ahead of its first reader in the core domain
    srd_rx_if rx ();

    // core domain: rate resolution and control registers
    logic [3:0] ctrl_r, ctrl_nxt;
    logic txFull_r, txFull_nxt;
    logic rxFull_r, rxFull_nxt;
    logic [1:0] rlgSync_r;
    logic rlgPrev_r, rlgPrev_nxt;
    logic rlgPulse_r, rlgPulse_nxt;

    always_comb
    begin
        txFull_nxt = txSpeedSel;
        rxFull_nxt = splitRateMode ? rxSpeedSel : txSpeedSel;
        ctrl_nxt = {loopbackSelect, alignEnable, txFull_nxt, rxFull_nxt};
        rlgPrev_nxt = rlgSync_r[1];
        rlgPulse_nxt = rlgSync_r[1] ^ rlgPrev_r;
    end

    always_ff @(posedge core_clk or negedge coreRstN)
    begin
        if (!coreRstN)
        begin
            ctrl_r <= CTRL_RST;
            txFull_r <= 1'b0;
            rxFull_r <= 1'b0;
            rlgSync_r <= SYNC_RST;
            rlgPrev_r <= 1'b0;
            rlgPulse_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            txFull_r <= txFull_nxt;
            rxFull_r <= rxFull_nxt;
            rlgSync_r <= {rlgSync_r[0], rx.realignTgl};
            rlgPrev_r <= rlgPrev_nxt;
            rlgPulse_r <= rlgPulse_nxt;
        end
    end

    assign txFullSpeed = txFull_r;
    assign rxFullSpeed = rxFull_r;
    assign realignPulse = rlgPulse_r;

    // link domain: synchronisers for control levels and pins
    logic [3:0] ctrlS1_r;
    logic [3:0] ctrlS2_r;
    logic [PIN_W-1:0] pinS1_r;
    logic [PIN_W-1:0] pinS2_r;
    logic txClkS;
    logic [WORD_BITS-1:0] txDataS;
    logic inPS;
    logic inNS;
    srd_rate_t tx_speed_sel;
    srd_rate_t rx_speed_sel;
    logic loopOn;

    always_ff @(posedge serialBitClk or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            ctrlS1_r <= CTRL_RST;
            ctrlS2_r <= CTRL_RST;
            pinS1_r <= '0;
            pinS2_r <= '0;
        end
        else
        begin
            ctrlS1_r <= ctrl_r;
            ctrlS2_r <= ctrlS1_r;
            pinS1_r <= {txWordClock, txParallelWord, serialInP, serialInN};
            pinS2_r <= pinS1_r;
        end
    end

    assign txClkS = pinS2_r[PIN_W-1];
    assign txDataS = pinS2_r[PIN_W-2:2];
    assign inPS = pinS2_r[1];
    assign inNS = pinS2_r[0];
    assign tx_speed_sel = ctrlS2_r[CTL_TXFULL] ? SRD_FULL : SRD_HALF;
    assign rx_speed_sel = ctrlS2_r[CTL_RXFULL] ? SRD_FULL : SRD_HALF;
    assign loopOn = ctrlS2_r[CTL_LOOP];

    // transmit: word capture and serializer
    logic txClkPrev_r, txClkPrev_nxt;
    logic txPhase_r, txPhase_nxt;
    logic [WORD_BITS-1:0] txShift_r, txShift_nxt;
    logic serP_r, serP_nxt;
    logic serN_r, serN_nxt;
    logic txStb;

    always_comb
    begin
        txClkPrev_nxt = txClkS;
        txPhase_nxt = ~txPhase_r;
        // half speed sends one bit every second bit-clock cycle
        txStb = (tx_speed_sel == SRD_FULL) || txPhase_r;
        txShift_nxt = txShift_r;
        if (txClkS && !txClkPrev_r)
        begin
            txShift_nxt = txDataS;
            // restart the half-speed phase so every bit stands two cycles
            txPhase_nxt = 1'b0;
        end
        else if (txStb)
        begin
            txShift_nxt = {1'b0, txShift_r[WORD_BITS-1:1]};
        end
        case (loopOn)
            1'b1:
            begin
                serP_nxt = 1'b1;
                serN_nxt = 1'b0;
            end
            1'b0:
            begin
                serP_nxt = txShift_r[0];
                serN_nxt = ~txShift_r[0];
            end
            default:
            begin
                serP_nxt = 1'b1;
                serN_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge serialBitClk or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            txClkPrev_r <= 1'b0;
            txPhase_r <= 1'b0;
            txShift_r <= WORD_RST;
            serP_r <= 1'b1;
            serN_r <= 1'b0;
        end
        else
        begin
            txClkPrev_r <= txClkPrev_nxt;
            txPhase_r <= txPhase_nxt;
            txShift_r <= txShift_nxt;
            serP_r <= serP_nxt;
            serN_r <= serN_nxt;
        end
    end

    assign serialOutP = serP_r;
    assign serialOutN = serN_r;

    // receive: bit strobe, alignment and recovered clocks

    logic rxPhase_r, rxPhase_nxt;
    logic rwc_r, rwc_nxt;
    logic rwcInv_r, rwcInv_nxt;

    always_comb
    begin
        rxPhase_nxt = ~rxPhase_r;
        // clock runs on from the synthesizer even with no input data, but holds while loopOn stops the bit strobe
        rwc_nxt = (rx.bitCnt >= RWC_RISE_CNT) && (rx.bitCnt < CNT_LAST);
        rwcInv_nxt = ~rwc_nxt;
    end

    always_ff @(posedge serialBitClk or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            rxPhase_r <= 1'b0;
            rwc_r <= 1'b0;
            rwcInv_r <= 1'b1;
        end
        else
        begin
            rxPhase_r <= rxPhase_nxt;
            rwc_r <= rwc_nxt;
            rwcInv_r <= rwcInv_nxt;
        end
    end

    assign rx.bitStb = ((rx_speed_sel == SRD_FULL) || rxPhase_r) && !loopOn;
    assign rx.serBit = inPS & ~inNS;
    assign rx.alignEn = ctrlS2_r[CTL_ALIGN];

    srd_comma_align uAlign (
        .clk(serialBitClk),
        .rstN(linkRstN),
        .rx(rx.align)
    );

    assign rxParallelWord = rx.word;
    assign commaSeenFlag = rx.comma;
    assign recoveredWordClock = rwc_r;
    assign recoveredWordClockInv = rwcInv_r;
endmodule
